// File: rtl/tpc_pkg.sv
// Purpose: shared constants for the transmit payload control block
// Assumes: one framer copy per instance, 100 MHz system clock
// Notes:   offsets are byte addresses on the 10-bit processor port
package tpc_pkg;

    // direct register offsets of framer 0, copies step by the stride
    localparam logic [9:0] OFS_CONFIG    = 10'h030; // configuration
    localparam logic [9:0] OFS_STATUS    = 10'h031; // access status
    localparam logic [9:0] OFS_ADDR_CTRL = 10'h032; // address/control
    localparam logic [9:0] OFS_DATA_BUF  = 10'h033; // data buffer
    localparam int         STRIDE_SHIFT  = 7;       // stride 080h

    // field positions
    localparam int CFG_ENABLE_BIT = 0; // per_channel_enable
    localparam int STAT_BUSY_BIT  = 7; // busy flag
    localparam int AC_DIR_BIT     = 7; // access_direction, 1 = read

    // per-channel control byte
    localparam int CC_INVERT   = 7; // invert all bits
    localparam int CC_FILL     = 6; // fill_substitute_en
    localparam int CC_MW       = 5; // milliwatt_substitute_en
    localparam int CC_MSB_FLIP = 4; // msb_flip
    localparam int CC_TEST     = 3; // test pattern slot
    localparam int CC_LOOP     = 2; // payload loopback
    localparam int CC_ZCS_HI   = 1; // zero_suppress_mode msb
    localparam int CC_ZCS_LO   = 0; // zero_suppress_mode lsb

    // signaling control byte
    localparam int SC_SRC_SEL = 7; // signaling_source_sel
    localparam int SC_REPLACE = 6; // signaling_replace_en

    // zero suppression codes and the bits they force
    localparam logic [1:0] ZCS_OFF    = 2'h0;
    localparam logic [1:0] ZCS_ALWAYS = 2'h1;
    localparam logic [1:0] ZCS_B8_SIG = 2'h2;
    localparam logic [1:0] ZCS_B7     = 2'h3;
    localparam int         BIT8_POS   = 0; // bit 8 is the lsb
    localparam int         BIT7_POS   = 1;

    // indirect map
    localparam int         NUM_CH     = 24;
    localparam int         NUM_IND    = 72;
    localparam logic [6:0] IDX_FIRST  = 7'h01;
    localparam logic [6:0] IDX_LAST   = 7'h48;
    localparam logic [6:0] FILL_BASE  = 7'h18; // idle bytes 19h..30h
    localparam logic [6:0] SIG_BASE   = 7'h30; // signaling 31h..48h
    localparam logic [4:0] LAST_CH    = 5'h17;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // access timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ACCESS_NS     = 650;
    localparam int READ_NS       = 490;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS; // least, rounded up
    localparam int READ_CYC   = READ_NS / CLK_PERIOD_NS; // longest
    localparam logic [6:0] ACCESS_CNT = 7'(ACCESS_CYC);
    localparam logic [6:0] XFER_CNT   = 7'(READ_CYC - 1);

    typedef enum logic {IA_IDLE, IA_ACCESS} tpc_state_t;

    // index inside the documented window
    function automatic logic idx_valid(input logic [6:0] idx);
        return (idx >= IDX_FIRST) && (idx <= IDX_LAST);
    endfunction

    // digital milliwatt sequence, eight bytes per cycle
    function automatic logic [7:0] mw_byte(input logic [2:0] ph);
        case (ph)
            3'h0, 3'h3: return 8'h1e;
            3'h1, 3'h2: return 8'h0b;
            3'h4, 3'h7: return 8'h9e;
            default:    return 8'h8b;
        endcase
    endfunction

endpackage

// File: rtl/tpc_chan_proc.sv
// Purpose: per-channel byte and signaling manipulation, combinational
// Assumes: caller registers the results
// Notes:   later assignments override earlier ones, lowest rank first
`timescale 1ns/1ps
`default_nettype none
module tpc_chan_proc (
    input  wire logic       enable,    // per-channel functions on
    input  wire logic [7:0] ctrl,      // per-channel control byte
    input  wire logic [7:0] fill,      // stored idle code
    input  wire logic [7:0] sig_ctrl,  // signaling control byte
    input  wire logic [7:0] raw,       // incoming channel byte
    input  wire logic [3:0] sig_in,    // incoming signaling nibble
    input  wire logic       sig_frame, // signaling frame flag
    input  wire logic [7:0] mw,        // milliwatt byte now due
    input  wire logic [7:0] gen,       // generator byte
    input  wire logic [7:0] loop,      // looped receive byte
    input  wire logic       loop_ok,   // loopback timing allowed
    input  wire logic       pat_sel,   // 1 = extract to detector
    output logic      [7:0] out_byte,  // processed byte
    output logic      [3:0] sig_out,   // chosen signaling
    output logic            extract,   // byte goes to detector
    output logic            gen_take   // generator byte consumed
);
    // byte pipeline, lowest priority first
    always_comb begin
        out_byte = raw;
        sig_out  = sig_in;
        extract  = 1'b0;
        gen_take = 1'b0;
        if (enable) begin
            case ({ctrl[tpc_pkg::CC_INVERT],
                   ctrl[tpc_pkg::CC_MSB_FLIP]})
                2'b01:   out_byte = raw ^ 8'h80;
                2'b10:   out_byte = ~raw;
                2'b11:   out_byte = raw ^ 8'h7f;
                default: out_byte = raw;
            endcase
            if (ctrl[tpc_pkg::CC_FILL]) begin
                out_byte = fill;
            end
            // test slots form one concatenated stream
            if (ctrl[tpc_pkg::CC_TEST]) begin
                if (pat_sel) begin
                    extract = 1'b1;
                end else begin
                    out_byte = gen;
                    gen_take = 1'b1;
                end
            end
            if (ctrl[tpc_pkg::CC_MW]) begin
                out_byte = mw;
            end
            if (ctrl[tpc_pkg::CC_LOOP] && loop_ok) begin
                out_byte = loop;
            end
            // zero suppression ranks just below extraction
            case (ctrl[tpc_pkg::CC_ZCS_HI:tpc_pkg::CC_ZCS_LO])
                tpc_pkg::ZCS_ALWAYS: begin
                    out_byte[tpc_pkg::BIT8_POS] = 1'b1;
                end
                tpc_pkg::ZCS_B8_SIG: begin
                    if (out_byte == 8'h00 && sig_frame) begin
                        out_byte[tpc_pkg::BIT7_POS] = 1'b1;
                    end else if (out_byte == 8'h00) begin
                        out_byte[tpc_pkg::BIT8_POS] = 1'b1;
                    end
                end
                tpc_pkg::ZCS_B7: begin
                    if (out_byte == 8'h00) begin
                        out_byte[tpc_pkg::BIT7_POS] = 1'b1;
                    end
                end
                default: begin
                    out_byte = out_byte;
                end
            endcase
            // source select only counts when replace is set
            if (sig_ctrl[tpc_pkg::SC_REPLACE]) begin
                sig_out = sig_ctrl[tpc_pkg::SC_SRC_SEL] ?
                          sig_ctrl[3:0] : sig_in;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/tpc_payload_ctrl.sv
// Purpose: transmit per-channel payload controller of one framer
// Assumes: processor strobes and channel bytes are clk-synchronous
// Notes:   channel bytes arrive already deserialised, one per strobe
//
// Contract
// - register copy at 030h, stride 080h per framer
// - per-channel operations only when enable set
// - busy flag bit 7 refuses new accesses
// - access lasts 650 ns, busy then clears
// - address/control write starts an access
// - direction bit 7: 0 write, 1 read
// - seven-bit index valid from 01h to 48h
// - read byte lands in buffer within 490 ns
// - indirect map: control, idle, signaling bytes
// - two inversion bits select flip pattern
// - idle bit substitutes stored idle code
// - milliwatt bit substitutes milliwatt pattern
// - test bit extracts or inserts pattern data
// - test slots form one continuous stream
// - loopback with receive clock master mode
// - slave loopback needs identical clocks, pulses
// - code 01 forces bit 8 always
// - code 10 forces bit 8, bit 7 signaling
// - code 11 forces bit 7; 00 off
// - operation priority, extraction highest, inversion lowest
// - source select acts only when replace set
// - select 0 pin nibble, 1 stored nibble
// - replace bit clear passes signaling through
`timescale 1ns/1ps
`default_nettype none
module tpc_payload_ctrl #(
    parameter logic [2:0] FRAMER_IDX = 3'h0  // framer copy number
) (
    input  wire logic       clk,                  // 100 MHz clock
    input  wire logic       arst_n,               // async reset, low
    input  wire logic [9:0] cpu_addr,             // register address
    input  wire logic       cpu_cs,               // chip select
    input  wire logic       cpu_wr,               // write strobe
    input  wire logic       cpu_rd,               // read strobe
    input  wire logic [7:0] cpu_wdata,            // write data
    output logic      [7:0] cpu_rdata,            // read data
    input  wire logic       ch_valid,             // channel byte strobe
    input  wire logic [4:0] ch_num,               // channel 0..23
    input  wire logic [7:0] transmit_serial_data, // channel byte in
    input  wire logic [3:0] transmit_signaling_input, // abcd in
    input  wire logic       sig_frame,            // signaling frame
    input  wire logic [7:0] loop_data,            // receive payload
    input  wire logic       rx_clock_master,      // rx master mode
    input  wire logic       tx_clock_slave,       // tx slave mode
    input  wire logic       timing_identical,     // clocks, pulses same
    input  wire logic       pattern_direction_sel, // 1 = detect
    input  wire logic [7:0] pattern_gen_data,     // generator byte
    output logic            pattern_gen_take,     // generator pop
    output logic            pattern_det_valid,    // detector strobe
    output logic      [7:0] pattern_det_data,     // detector byte
    output logic            out_valid,            // processed strobe
    output logic      [4:0] out_num,              // its channel
    output logic      [7:0] out_data,             // processed byte
    output logic      [3:0] sig_out               // signaling out
);

    // reset release through two flops
    logic rst_meta_reg;  // first stage
    logic rst_n;         // released reset

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // register state
    logic [7:0]          config_reg;    // tx_channel_ctrl_config
    logic [7:0]          addr_ctrl_reg; // indirect_addr_ctrl
    logic [7:0]          data_buf_reg;  // indirect_data_buffer
    logic [7:0]          mem [tpc_pkg::NUM_IND]; // indirect bytes
    tpc_pkg::tpc_state_t state_reg;     // access engine state
    logic [6:0]          cnt_reg;       // cycles into the access
    logic [2:0]          mw_phase_reg;  // milliwatt frame phase

    // bus decode
    logic [9:0] off;        // address relative to this copy
    logic       wr_hit;     // write strobe
    logic       rd_hit;     // read strobe
    logic       busy;       // access in progress
    logic       start;      // accepted access request
    logic       xfer;       // data moves this cycle
    logic [6:0] ac_slot;    // array slot of the access

    // each framer copy sits one stride above the last
    assign off = cpu_addr - {FRAMER_IDX, 7'h00};
    assign wr_hit = cpu_cs && cpu_wr;
    assign rd_hit = cpu_cs && cpu_rd;
    assign busy   = (state_reg == tpc_pkg::IA_ACCESS);
    // out-of-range index writes store but start nothing
    assign start  = wr_hit && !busy
                    && (off == tpc_pkg::OFS_ADDR_CTRL)
                    && tpc_pkg::idx_valid(cpu_wdata[6:0]);
    assign xfer    = busy && (cnt_reg == tpc_pkg::XFER_CNT);
    assign ac_slot = addr_ctrl_reg[6:0] - tpc_pkg::IDX_FIRST;

    // direct register writes
    // address/control and buffer are frozen while busy, so a
    // careless host cannot corrupt the cycle under way
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg    <= tpc_pkg::RESET_BYTE;
            addr_ctrl_reg <= tpc_pkg::RESET_BYTE;
        end else if (wr_hit) begin
            if (off == tpc_pkg::OFS_CONFIG) begin
                config_reg <= cpu_wdata;
            end else if (off == tpc_pkg::OFS_ADDR_CTRL && !busy) begin
                addr_ctrl_reg <= cpu_wdata;
            end
        end
    end

    // data buffer: host load, or engine read result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_buf_reg <= tpc_pkg::RESET_BYTE;
        end else if (xfer && addr_ctrl_reg[tpc_pkg::AC_DIR_BIT]) begin
            data_buf_reg <= mem[ac_slot];
        end else if (wr_hit && !busy
                     && off == tpc_pkg::OFS_DATA_BUF) begin
            data_buf_reg <= cpu_wdata;
        end
    end

    // access engine: one fixed-length cycle per request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= tpc_pkg::IA_IDLE;
            cnt_reg   <= 7'h00;
        end else begin
            case (state_reg)
                tpc_pkg::IA_IDLE: begin
                    if (start) begin
                        state_reg <= tpc_pkg::IA_ACCESS;
                        cnt_reg   <= 7'h01;
                    end
                end
                tpc_pkg::IA_ACCESS: begin
                    cnt_reg <= cnt_reg + 7'h01;
                    // busy drops after the full access time
                    if (cnt_reg == tpc_pkg::ACCESS_CNT) begin
                        state_reg <= tpc_pkg::IA_IDLE;
                        cnt_reg   <= 7'h00;
                    end
                end
                default: begin
                    state_reg <= tpc_pkg::IA_IDLE;
                    cnt_reg   <= 7'h00;
                end
            endcase
        end
    end

    // indirect bytes, cleared so a bypassed block stays defined
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < tpc_pkg::NUM_IND; i++) begin
                mem[i] <= tpc_pkg::RESET_BYTE;
            end
        end else if (xfer && !addr_ctrl_reg[tpc_pkg::AC_DIR_BIT]) begin
            mem[ac_slot] <= data_buf_reg;
        end
    end

    // read port, answers one cycle after the strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata <= 8'h00;
        end else if (rd_hit) begin
            case (off)
                tpc_pkg::OFS_CONFIG:    cpu_rdata <= config_reg;
                tpc_pkg::OFS_STATUS:    cpu_rdata <= {busy, 7'h00};
                tpc_pkg::OFS_ADDR_CTRL: cpu_rdata <= addr_ctrl_reg;
                tpc_pkg::OFS_DATA_BUF:  cpu_rdata <= data_buf_reg;
                default:                cpu_rdata <= 8'h00;
            endcase
        end
    end

    // channel lookup
    logic       ch_ok;     // strobe for a legal channel
    logic [6:0] ch_slot;   // control byte slot
    logic       loop_ok;   // loopback timing permitted
    logic [7:0] proc_byte; // processed byte
    logic [3:0] proc_sig;  // processed signaling
    logic       proc_ext;  // extraction request
    logic       proc_take; // generator consumption

    assign ch_ok   = ch_valid && (ch_num <= tpc_pkg::LAST_CH);
    assign ch_slot = {2'b00, ch_num};
    // slave loopback has no elastic store, so timing must match
    assign loop_ok = rx_clock_master
                     || (tx_clock_slave && timing_identical);

    // milliwatt phase advances once per frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mw_phase_reg <= 3'h0;
        end else if (ch_ok && ch_num == tpc_pkg::LAST_CH) begin
            mw_phase_reg <= mw_phase_reg + 3'h1;
        end
    end

    tpc_chan_proc u_proc (
        .enable    (config_reg[tpc_pkg::CFG_ENABLE_BIT] && ch_ok),
        .ctrl      (mem[ch_slot]),
        .fill      (mem[ch_slot + tpc_pkg::FILL_BASE]),
        .sig_ctrl  (mem[ch_slot + tpc_pkg::SIG_BASE]),
        .raw       (transmit_serial_data),
        .sig_in    (transmit_signaling_input),
        .sig_frame (sig_frame),
        .mw        (tpc_pkg::mw_byte(mw_phase_reg)),
        .gen       (pattern_gen_data),
        .loop      (loop_data),
        .loop_ok   (loop_ok),
        .pat_sel   (pattern_direction_sel),
        .out_byte  (proc_byte),
        .sig_out   (proc_sig),
        .extract   (proc_ext),
        .gen_take  (proc_take)
    );

    // generator pop is a handshake, left combinational
    assign pattern_gen_take = proc_take && rst_n;

    // output stage, one cycle behind the input strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid         <= 1'b0;
            out_num           <= 5'h00;
            out_data          <= 8'h00;
            sig_out           <= 4'h0;
            pattern_det_valid <= 1'b0;
            pattern_det_data  <= 8'h00;
        end else begin
            out_valid         <= ch_valid;
            pattern_det_valid <= proc_ext;
            if (ch_valid) begin
                out_num  <= ch_num;
                out_data <= proc_byte;
                sig_out  <= proc_sig;
            end
            // extraction sees the raw byte, before any change
            if (proc_ext) begin
                pattern_det_data <= transmit_serial_data;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [7:0] chk_byte_reg;  // value expected after an access

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chk_byte_reg <= 8'h00;
        end else if (start) begin
            chk_byte_reg <= cpu_wdata[tpc_pkg::AC_DIR_BIT] ?
                            mem[cpu_wdata[6:0] - tpc_pkg::IDX_FIRST]
                            : data_buf_reg;
        end
    end

    logic en_now;  // block enable seen by the datapath
    assign en_now = config_reg[tpc_pkg::CFG_ENABLE_BIT];

    sequence s_access_span;
        busy ##64 busy ##1 !busy;
    endsequence

    a_busy_span: assert property (start |=> s_access_span)
        else $error("busy span differs from 65 cycles");

    a_busy_refuse: assert property (
        busy && wr_hit && off == tpc_pkg::OFS_ADDR_CTRL
        |=> $stable(addr_ctrl_reg) && busy)
        else $error("address/control changed during busy");

    a_bad_index: assert property (
        !busy && wr_hit && off == tpc_pkg::OFS_ADDR_CTRL
        && !tpc_pkg::idx_valid(cpu_wdata[6:0]) |=> !busy)
        else $error("invalid index started an access");

    a_read_lands: assert property (
        start && cpu_wdata[tpc_pkg::AC_DIR_BIT]
        |-> ##49 data_buf_reg == chk_byte_reg)
        else $error("read data missing from buffer");

    a_write_lands: assert property (
        start && !cpu_wdata[tpc_pkg::AC_DIR_BIT]
        |-> ##49 mem[ac_slot] == chk_byte_reg)
        else $error("buffered byte not written");

    a_status_busy: assert property (
        rd_hit && off == tpc_pkg::OFS_STATUS
        |=> cpu_rdata[tpc_pkg::STAT_BUSY_BIT] == $past(busy))
        else $error("status bit 7 does not show busy");

    a_bypass_data: assert property (
        ch_valid && !en_now
        |=> out_valid && out_data == $past(transmit_serial_data))
        else $error("bypass altered channel byte");

    a_zcs_always: assert property (
        ch_ok && en_now
        && mem[ch_slot][1:0] == tpc_pkg::ZCS_ALWAYS
        |=> out_data[tpc_pkg::BIT8_POS])
        else $error("bit 8 not forced");

    a_extract_raw: assert property (
        ch_ok && en_now && pattern_direction_sel
        && mem[ch_slot][tpc_pkg::CC_TEST]
        |=> pattern_det_valid
            && pattern_det_data == $past(transmit_serial_data))
        else $error("test byte not sent to detector");

    a_sig_pass: assert property (
        ch_valid && (!en_now || !ch_ok
        || !mem[ch_slot + tpc_pkg::SIG_BASE][tpc_pkg::SC_REPLACE])
        |=> sig_out == $past(transmit_signaling_input))
        else $error("signaling changed without replace");

endmodule
`default_nettype wire

// File: testbench/tpc_gen_model.sv
// Purpose: pattern generator model at the far side of the test slots
// Assumes: take is a one-cycle pop sampled on the rising edge
// Notes:   bytes follow an lfsr so a stale or skipped byte shows up
`timescale 1ns/1ps
`default_nettype none
module tpc_gen_model (
    input  wire logic       clk,      // system clock
    input  wire logic       arst_n,   // async reset, low
    input  wire logic       take,     // byte consumed
    output logic      [7:0] gen_data  // byte offered
);
    // step only on a pop, so all test slots share one stream
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            gen_data <= 8'h5a;
        else if (take)
            gen_data <= {gen_data[6:0],
                gen_data[7] ^ gen_data[5] ^ gen_data[3]};
    end
endmodule
`default_nettype wire

// File: testbench/tb_tpc_payload_ctrl.sv
// Purpose: self-checking bench for the transmit payload controller
// Assumes: second framer copy, so its registers sit at 0b0h
// Notes:   only channel 5 is sent, so the milliwatt phase stays at 0
`timescale 1ns/1ps
`default_nettype none
module tb_tpc_payload_ctrl;
    logic       clk = 0, arst_n = 0, cs = 0, wr = 0, rd = 0; // bus
    logic       ch_valid = 0, rx_m = 0, ps = 0, sf = 0, ts = 0, ti = 0;
    logic [9:0] addr = 10'h000;                  // register address
    logic [7:0] wdata = 0, tsd = 0, lp = 0, d, l, c; // data in
    logic [3:0] sig_in = 0, so, si, s4;          // signaling in, out
    logic [4:0] m;                               // random mode bits
    logic [4:0] num = 0, onum;                   // channel numbers
    logic [7:0] rdata, gen, det, od, s, fill;    // observed, scratch
    logic       take, dv, ov;                    // strobes out
    logic [20:0] q[$], e;                        // {det, det, sig, byte}
    logic [7:0] tbl[13] = '{8'h00, 8'h10, 8'h80, 8'h90, 8'h40,
                            8'h08, 8'h04, 8'h01, 8'h03, 8'h42,
                            8'h20, 8'hc3, 8'h02};
    int         failures = 0, compares = 0, seed = 2007;
    localparam logic [9:0] B = 10'h080;          // framer 1 offset
    always #5 clk = ~clk;
    tpc_payload_ctrl #(.FRAMER_IDX(3'h1)) tpc_payload_ctrl_inst (
        .clk(clk), .arst_n(arst_n), .cpu_addr(addr), .cpu_cs(cs),
        .cpu_wr(wr), .cpu_rd(rd), .cpu_wdata(wdata), .cpu_rdata(rdata),
        .ch_valid(ch_valid), .ch_num(num), .transmit_serial_data(tsd),
        .transmit_signaling_input(sig_in), .sig_frame(sf),
        .loop_data(lp), .rx_clock_master(rx_m), .tx_clock_slave(ts),
        .timing_identical(ti), .pattern_direction_sel(ps),
        .pattern_gen_data(gen), .pattern_gen_take(take),
        .pattern_det_valid(dv), .pattern_det_data(det), .out_valid(ov),
        .out_num(onum), .out_data(od), .sig_out(so));
    tpc_gen_model tpc_gen_model_inst (.clk(clk), .arst_n(arst_n),
        .take(take), .gen_data(gen));
    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        compares++;
        if (g !== x) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic complete_run;
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one bus cycle; a read leaves its byte in s
    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [7:0] v);
        @(posedge clk);
        cs <= 1;
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        cs <= 0;
        wr <= 0;
        rd <= 0;
        @(posedge clk);
        #1 s = rdata;
    endtask
    // indirect access; buffer or address writes during busy are refused
    task automatic ind(input logic r, input logic [6:0] i,
                       input logic [7:0] v);
        int n;
        n = 0;
        if (!r) bus(1, tpc_pkg::OFS_DATA_BUF + B, v);
        bus(1, tpc_pkg::OFS_ADDR_CTRL + B, {r, i});
        bus(0, tpc_pkg::OFS_STATUS + B, 8'h00);
        chk(s, 8'h80);
        if (!r) bus(1, tpc_pkg::OFS_DATA_BUF + B, ~v);
        if (r) bus(1, tpc_pkg::OFS_ADDR_CTRL + B, {1'b1, i ^ 7'h01});
        while (s[7] !== 1'b0 && n < 100) begin
            bus(0, tpc_pkg::OFS_STATUS + B, 8'h00);
            n++;
        end
        chk(8'(n > 15 && n < 100), 8'h01);
        if (n == 100) complete_run();
        if (r) bus(0, tpc_pkg::OFS_DATA_BUF + B, 8'h00);
        if (r) chk(s, v);
    endtask
    // expected byte, lowest rank applied first so higher ones win
    // r: detect, signaling frame, rx master, tx slave, timing same
    function automatic logic [7:0] expb(input logic [7:0] c, x, g, lb,
                                        input logic [4:0] r);
        logic [7:0] v;
        v = x ^ {c[7] ^ c[4], {7{c[7]}}};
        if (c[6]) v = fill;
        if (c[3] && !r[0]) v = g;
        if (c[5]) v = 8'h1e;
        if (c[2] && (r[2] || (r[3] && r[4]))) v = lb;
        if (c[1:0] == 2'h1) v[0] = 1'b1;
        if (c[1:0] == 2'h2 && v == 0) v[r[1]] = 1'b1;
        if (c[1:0] == 2'h3 && v == 0) v[1] = 1'b1;
        return v;
    endfunction
    // registered outputs checked mid-cycle against the oldest note
    always @(negedge clk) begin
        if (ov === 1'b1) begin
            e = (q.size() == 0) ? 'x : q.pop_front();
            chk(od, e[7:0]);
            chk({4'h0, so}, {4'h0, e[11:8]});
            chk({3'h0, onum}, 8'h05);
            chk({7'h00, dv}, {7'h00, e[20]});
            if (e[20] === 1'b1) chk(det, e[19:12]);
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        arst_n <= 1;
        repeat (3) @(posedge clk);
        for (int k = 1; k < 4; k++) begin
            bus(0, tpc_pkg::OFS_CONFIG + B + 10'(k), 8'h00);
            chk(s, 8'h00);
        end
        bus(1, tpc_pkg::OFS_ADDR_CTRL + B, 8'h49);
        bus(0, tpc_pkg::OFS_STATUS + B, 8'h00);
        chk(s, 8'h00);
        fill = 8'($random(seed));
        ind(0, tpc_pkg::FILL_BASE + 7'h06, fill);
        for (int en = 0; en < 2; en++) begin
            bus(1, tpc_pkg::OFS_CONFIG + B, 8'(en));
            foreach (tbl[k]) begin
                ind(0, 7'h06, tbl[k]);
                ind(1, 7'h06, tbl[k]);
                ind(0, tpc_pkg::SIG_BASE + 7'h06, tbl[k]);
                c = tbl[k];
                for (int j = 0; j < 3; j++) begin
                    @(posedge clk);
                    d = (j == 0) ? 8'h00 : 8'($random(seed));
                    l = 8'($random(seed));
                    m = 5'($random(seed));
                    si = 4'($random(seed));
                    ch_valid <= 1;
                    num <= 5'h05;
                    tsd <= d;
                    lp <= l;
                    sig_in <= si;
                    {ti, ts, rx_m, sf, ps} <= m;
                    s4 = (en == 1 && c[6] && c[7]) ? c[3:0] : si;
                    q.push_back({(en == 1) && c[3] && m[0], d, s4,
                                 en ? expb(c, d, gen, l, m) : d});
                    @(posedge clk);
                    ch_valid <= 0;
                end
            end
        end
        repeat (4) @(posedge clk);
        chk(8'(q.size()), 8'h00);
        bus(0, tpc_pkg::OFS_ADDR_CTRL, 8'h00);
        chk(s, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
